// ===== shared/rpf_consts.svh
`ifndef RPF_CONSTS_SVH
`define RPF_CONSTS_SVH
`define RPF_FIFO_DEPTH 5'h10
`define RPF_FIFO_HALF 5'h08
`define RPF_MAX_PKT 6'h28
`define RPF_SOP_SYMS 2'h2
`define RPF_LEN_BITS 4'h8
`define RPF_CRC_BITS 5'h10
`define RPF_CRC_POLY_REF 16'ha001
`define RPF_CRC_ZERO 16'h0000
`define RPF_CORR_START 2'h2
`define RPF_RATE_GFSK 17'h186a0
`define RPF_RATE_OCT32 17'h061a8
`define RPF_RATE_OCT64 17'h030d4
`define RPF_RATE_DBL32 17'h0186a
`define RPF_RATE_DBL64 17'h00c35
`define RPF_RATE_SGL64 17'h0061b
`endif

// ===== shared/rpf_pkg.sv
package rpf_pkg;
   typedef enum logic [2:0] {
      RPF_GFSK = 3'h0,
      RPF_OCT32 = 3'h1,
      RPF_OCT64 = 3'h2,
      RPF_DBL32 = 3'h3,
      RPF_DBL64 = 3'h4,
      RPF_SGL64 = 3'h5
   } rpf_mode_e;

   typedef struct packed {
      rpf_mode_e mode;
      logic framing_en;
      logic sop_en;
      logic len_en;
      logic crc_en;
      logic crc_zero_seed;
      logic [15:0] crc_seed;
      logic [3:0] nocorr_limit;
   } rpf_cfg_s;

   typedef struct packed {
      logic clk;
      logic data;
      logic corr;
      logic sop;
      rpf_mode_e rate;
   } rpf_link_s;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_SOP = 3'b001,
      TX_LEN = 3'b010,
      TX_PAY = 3'b011,
      TX_CRC = 3'b100,
      TX_FIN = 3'b101
   } rpf_txst_e;

   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_LEN = 2'b01,
      RX_PAY = 2'b10,
      RX_CRC = 2'b11
   } rpf_rxst_e;
endpackage : rpf_pkg

// ===== test/rpf_framer_sva.sv
`timescale 1ns/1ps
`default_nettype none
module rpf_framer_sva (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire rpf_pkg::rpf_cfg_s i_cfg,
   input wire logic i_txb_wr,
   input wire logic i_tx_start,
   input wire logic [5:0] i_tx_len,
   input wire logic i_rxb_rd,
   input wire logic o_link_spread,
   input wire logic [4:0] o_tx_level,
   input wire logic [4:0] o_rx_level,
   input wire logic o_tx_low,
   input wire logic o_rx_high,
   input wire logic o_tx_busy,
   input wire logic o_tx_done,
   input wire logic o_rx_busy,
   input wire logic o_rx_done,
   input wire logic o_rx_crc_ok,
   input wire logic o_rx_crc_err
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   chk_level_bound: assert property (o_tx_level <= 5'h10 && o_rx_level <= 5'h10)
      else $error("fifo level above sixteen");
   // Flags lag the level by up to one cycle, so only settled levels are judged
   chk_tx_low_flag: assert property ($past(i_rst_n) && $stable(o_tx_level)
      |-> o_tx_low == (o_tx_level <= 5'h08)) else $error("tx low flag wrong");
   chk_rx_high_flag: assert property ($past(i_rst_n) && $stable(o_rx_level)
      |-> o_rx_high == (o_rx_level >= 5'h08)) else $error("rx high flag wrong");
   chk_tx_push_count: assert property ($past(i_rst_n) && i_txb_wr && !o_tx_busy
      && o_tx_level < 5'h10 |=> o_tx_level == $past(o_tx_level) + 5'h01)
      else $error("tx push not counted");
   chk_rx_pop_count: assert property (i_rxb_rd && !o_rx_busy && o_rx_level != 5'h00
      |=> o_rx_level == $past(o_rx_level) - 5'h01) else $error("rx pop not counted");
   chk_rx_pop_empty: assert property (i_rxb_rd && !o_rx_busy && o_rx_level == 5'h00
      |=> o_rx_level == 5'h00) else $error("empty pop changed level");
   chk_start_busy: assert property ($past(i_rst_n) && i_tx_start && !o_tx_busy
      && i_tx_len inside {[6'h01:6'h28]} |=> o_tx_busy) else $error("start not taken");
   chk_done_pulse: assert property (o_tx_done |=> !o_tx_done)
      else $error("tx done longer than a cycle");
   chk_crc_verdict: assert property (o_rx_crc_ok || o_rx_crc_err
      |-> o_rx_done && !(o_rx_crc_ok && o_rx_crc_err)) else $error("crc verdict bad");
   chk_spread_mode: assert property ($past(i_rst_n) && $stable(i_cfg.mode)
      |-> o_link_spread == (i_cfg.mode != rpf_pkg::RPF_GFSK)) else $error("spread wrong");
   cover property (o_rx_crc_ok);
   cover property (o_rx_crc_err);
   cover property (o_rx_level == 5'h10);
endmodule : rpf_framer_sva
bind rpf_framer rpf_framer_sva rpf_framer_sva_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
   .i_cfg(i_cfg), .i_txb_wr(i_txb_wr), .i_tx_start(i_tx_start), .i_tx_len(i_tx_len),
   .i_rxb_rd(i_rxb_rd), .o_link_spread(o_link_spread), .o_tx_level(o_tx_level),
   .o_rx_level(o_rx_level), .o_tx_low(o_tx_low), .o_rx_high(o_rx_high),
   .o_tx_busy(o_tx_busy), .o_tx_done(o_tx_done), .o_rx_busy(o_rx_busy),
   .o_rx_done(o_rx_done), .o_rx_crc_ok(o_rx_crc_ok), .o_rx_crc_err(o_rx_crc_err));
`default_nettype wire

// ===== test/rpf_framer_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "rpf_consts.svh"
module rpf_framer_test;
   logic i_clock = 1'b0;
   logic i_rst_n = 1'b0;
   rpf_pkg::rpf_cfg_s i_cfg = '0;
   logic i_txb_wr = 1'b0;
   logic [7:0] i_txb_data = 8'h00;
   logic i_tx_start = 1'b0;
   logic [5:0] i_tx_len = 6'h00;
   logic i_rxb_rd = 1'b0;
   rpf_pkg::rpf_link_s i_link;
   rpf_pkg::rpf_mode_e rate = rpf_pkg::RPF_GFSK;
   logic o_link_tx_bit, o_link_tx_en, o_link_sop_tx, o_link_spread, o_tx_low, o_rx_high;
   logic o_tx_busy, o_tx_done, o_tx_underrun, o_rx_busy, o_rx_done;
   logic o_rx_crc_ok, o_rx_crc_err, o_rx_overflow;
   logic [7:0] o_rxb_data;
   logic [4:0] o_tx_level, o_rx_level;
   logic [5:0] o_rx_len;
   logic [16:0] o_rate_x100;
   int error_cnt = 0;
   int check_count = 0;
   int txd_n = 0, rxd_n = 0, ok_n = 0, bad_n = 0, ovf_n = 0, und_n = 0;

   rpf_framer rpf_framer_inst (.*);
   rpf_link_peer rpf_link_peer_inst (.i_clock(i_clock), .i_tx_bit(o_link_tx_bit),
      .i_tx_en(o_link_tx_en), .i_sop_tx(o_link_sop_tx), .i_rate(rate), .o_link(i_link));

   always #10 i_clock = ~i_clock;
   // Events are one-cycle pulses, so count them as they pass
   always @(posedge i_clock) begin
      txd_n <= txd_n + int'(o_tx_done === 1'b1);
      rxd_n <= rxd_n + int'(o_rx_done === 1'b1);
      ok_n <= ok_n + int'(o_rx_crc_ok === 1'b1);
      bad_n <= bad_n + int'(o_rx_crc_err === 1'b1);
      ovf_n <= ovf_n + int'(o_rx_overflow === 1'b1);
      und_n <= und_n + int'(o_tx_underrun === 1'b1);
   end

   function automatic logic [7:0] pb(input int k);
      return 8'(k * 59) ^ 8'ha5;
   endfunction : pb
   function automatic logic [15:0] crc_of(input logic [15:0] seed, input int n);
      logic [15:0] c;
      logic [7:0] v;
      c = seed;
      for (int k = 0; k < n; k++) begin
         v = pb(k);
         for (int b = 0; b < 8; b++) begin
            c = (c >> 1) ^ ((c[0] ^ v[b]) ? 16'ha001 : 16'h0000);
         end
      end
      return c;
   endfunction : crc_of
   task automatic check(input string name, input logic [16:0] seen, input logic [16:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s exp %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic end_of_test();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_of_test
   task automatic tick();
      @(posedge i_clock);
      #2;
   endtask : tick
   // Two cycles a byte keep every strobe a clean single pulse
   task automatic push(input logic [7:0] d);
      i_txb_wr = 1'b1;
      i_txb_data = d;
      tick();
      i_txb_wr = 1'b0;
      tick();
   endtask : push
   task automatic pop();
      i_rxb_rd = 1'b1;
      tick();
      i_rxb_rd = 1'b0;
      tick();
   endtask : pop
   task automatic put(input int w, input logic [15:0] v, input logic [1:0] cs);
      for (int b = 0; b < w; b++) begin
         rpf_link_peer_inst.dq.push_back({cs, v[b % 16]});
      end
   endtask : put
   // Length, payload and CRC in line order, least significant bit first
   task automatic stream(input int n, input logic [15:0] c);
      put(8, 16'(n), 2'b00);
      for (int k = 0; k < n; k++) begin
         put(8, 16'(pb(k)), 2'b00);
      end
      put(16, c, 2'b00);
   endtask : stream

   task automatic rate_run();
      logic [16:0] tbl[6];
      tbl = '{`RPF_RATE_GFSK, `RPF_RATE_OCT32, `RPF_RATE_OCT64, `RPF_RATE_DBL32,
         `RPF_RATE_DBL64, `RPF_RATE_SGL64};
      for (int m = 0; m < 6; m++) begin
         i_cfg.mode = rpf_pkg::rpf_mode_e'(3'(m));
         tick();
         tick();
         check("rate", o_rate_x100, tbl[m]);
         check("spread", o_link_spread, m != 0);
      end
      i_cfg.mode = rpf_pkg::RPF_GFSK;
   endtask : rate_run

   task automatic tx_run(input int n, input logic zero);
      logic [2:0] exp[$];
      logic [2:0] q[$];
      logic [2:0] m;
      int d0;
      int t;
      int last;
      i_cfg.crc_zero_seed = zero;
      d0 = txd_n;
      put(2, 16'h0003, 2'b00);
      stream(n, crc_of(zero ? 16'h0000 : i_cfg.crc_seed, n));
      put(1, 16'h0000, 2'b00);
      exp = rpf_link_peer_inst.dq;
      last = exp.size() - 1;
      for (int k = 0; k < n && k < 16; k++) begin
         push(pb(k));
      end
      if (n > 15) check("tx_low", o_tx_low, 1'b0);
      i_tx_len = 6'(n);
      i_tx_start = 1'b1;
      tick();
      i_tx_start = 1'b0;
      check("tx_busy", o_tx_busy, 1'b1);
      check("rx_level", o_rx_level, 5'h00);
      fork
         rpf_link_peer_inst.play();
         for (int k = 16; k < n; k++) begin
            for (t = 0; t < 500 && o_tx_level > 5'h0f; t++) tick();
            if (t == 500) begin
               error_cnt++;
               end_of_test();
            end
            push(pb(k));
         end
      join
      q = rpf_link_peer_inst.txq;
      tick();
      check("tx_done", txd_n - d0, 1'b1);
      check("tx_underrun", und_n, 0);
      for (int b = 0; b <= last; b++) begin
         m = (b < 2 || b == last) ? 3'b110 : 3'b111;
         check("link_tx", q[b] & m, {b != last, b < 2, exp[b][0]} & m);
      end
   endtask : tx_run

   task automatic rx_run(input rpf_pkg::rpf_mode_e r, input int n, input logic z, input logic bad);
      int d0, o0, e0, v0;
      logic go;
      go = r != rpf_pkg::RPF_SGL64;
      d0 = rxd_n;
      o0 = ok_n;
      e0 = bad_n;
      v0 = ovf_n;
      rate = r;
      put(1, 16'h0000, 2'b01);
      stream(n, crc_of(z ? 16'h0000 : i_cfg.crc_seed, n) ^ 16'(bad));
      rpf_link_peer_inst.play();
      tick();
      check("rx_done", rxd_n - d0, go);
      check("rx_busy", o_rx_busy, 1'b0);
      check("crc_ok", ok_n - o0, go && !bad);
      check("crc_err", bad_n - e0, go && bad);
      check("overflow", ovf_n - v0, go && n > 16 ? n - 16 : 0);
      if (go && n > 15) check("rx_high", o_rx_high, 1'b1);
      if (go) check("rx_len", o_rx_len, 6'(n));
      for (int k = 0; go && k < n && k < 16; k++) begin
         pop();
         check("rx_data", o_rxb_data, pb(k));
      end
      pop();
      check("rx_empty", o_rx_level, 5'h00);
   endtask : rx_run

   task automatic raw_run();
      int d0;
      d0 = rxd_n;
      i_cfg.framing_en = 1'b0;
      i_cfg.crc_en = 1'b0;
      i_cfg.mode = rpf_pkg::RPF_DBL32;
      put(18, 16'hc3a5, 2'b10);
      put(4, 16'h0000, 2'b00);
      rpf_link_peer_inst.play();
      tick();
      check("raw_done", rxd_n - d0, 1'b1);
      check("raw_len", o_rx_len, 6'h02);
      pop();
      check("raw_data", o_rxb_data, 8'he9);
      pop();
      check("raw_data", o_rxb_data, 8'h70);
      pop();
      check("raw_empty", o_rx_level, 5'h00);
   endtask : raw_run

   initial begin
      i_cfg.framing_en = 1'b1;
      i_cfg.sop_en = 1'b1;
      i_cfg.len_en = 1'b1;
      i_cfg.crc_en = 1'b1;
      i_cfg.crc_seed = 16'h5a3c;
      i_cfg.nocorr_limit = 4'h3;
      repeat (12) @(posedge i_clock);
      #2 i_rst_n = 1'b1;
      tick();
      tick();
      check("tx_low", o_tx_low, 1'b1);
      check("tx_level", o_tx_level, 5'h00);
      rate_run();
      tx_run(3, 1'b0);
      tx_run(20, 1'b1);
      rx_run(rpf_pkg::RPF_GFSK, 3, 1'b0, 1'b0);
      rx_run(rpf_pkg::RPF_OCT32, 4, 1'b1, 1'b0);
      rx_run(rpf_pkg::RPF_DBL32, 2, 1'b0, 1'b1);
      rx_run(rpf_pkg::RPF_SGL64, 2, 1'b0, 1'b0);
      rx_run(rpf_pkg::RPF_GFSK, 20, 1'b0, 1'b0);
      raw_run();
      end_of_test();
   end
endmodule : rpf_framer_test
`default_nettype wire

// ===== test/rpf_link_peer.sv
`timescale 1ns/1ps
`default_nettype none
module rpf_link_peer (
   input wire logic i_clock,
   input wire logic i_tx_bit,
   input wire logic i_tx_en,
   input wire logic i_sop_tx,
   input wire rpf_pkg::rpf_mode_e i_rate,
   output var rpf_pkg::rpf_link_s o_link
);
   logic busy = 1'b0;
   logic [2:0] dq[$];
   logic [2:0] txq[$];
   initial o_link = '0;
   // A stale bit must never look valid between frames
   always @(posedge i_clock) begin
      if (!busy) begin
         o_link.data <= ~o_link.data;
      end
   end
   // Entries are {corr, marker, data}; the link clock runs only inside a frame
   task automatic play();
      busy = 1'b1;
      txq.delete();
      #1 o_link.rate = i_rate;
      foreach (dq[i]) begin
         {o_link.corr, o_link.sop, o_link.data} = dq[i];
         #10 o_link.clk = 1'b1;
         #80 o_link.clk = 1'b0;
         #70 txq.push_back({i_tx_en, i_sop_tx, i_tx_bit});
      end
      dq.delete();
      o_link.sop = 1'b0;
      o_link.corr = 1'b0;
      busy = 1'b0;
   endtask : play
endmodule : rpf_link_peer
`default_nettype wire

// ===== verilog/rpf_crc16.sv
`timescale 1ns/1ps
`default_nettype none
`include "rpf_consts.svh"
module rpf_crc16 (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_init,
   input wire logic [15:0] i_seed,
   input wire logic i_step,
   input wire logic i_bit,
   output logic [15:0] o_crc
);
   logic fb;

   // Bit-serial, reflected form, first transmitted bit first
   assign fb = o_crc[0] ^ i_bit;

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_crc <= `RPF_CRC_ZERO;
      end else if (i_init) begin
         o_crc <= i_seed;
      end else if (i_step) begin
         o_crc <= (o_crc >> 1) ^ (fb ? `RPF_CRC_POLY_REF : `RPF_CRC_ZERO);
      end
   end
endmodule : rpf_crc16
`default_nettype wire

// ===== verilog/rpf_framer.sv
`timescale 1ns/1ps
`default_nettype none
`include "rpf_consts.svh"
module rpf_framer (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire rpf_pkg::rpf_cfg_s i_cfg,
   input wire logic i_txb_wr,
   input wire logic [7:0] i_txb_data,
   input wire logic i_tx_start,
   input wire logic [5:0] i_tx_len,
   input wire logic i_rxb_rd,
   input wire rpf_pkg::rpf_link_s i_link,
   output logic o_link_tx_bit,
   output logic o_link_tx_en,
   output logic o_link_sop_tx,
   output logic o_link_spread,
   output logic [7:0] o_rxb_data,
   output logic [4:0] o_tx_level,
   output logic [4:0] o_rx_level,
   output logic o_tx_low,
   output logic o_rx_high,
   output logic o_tx_busy,
   output logic o_tx_done,
   output logic o_tx_underrun,
   output logic o_rx_busy,
   output logic o_rx_done,
   output logic o_rx_crc_ok,
   output logic o_rx_crc_err,
   output logic o_rx_overflow,
   output logic [5:0] o_rx_len,
   output logic [16:0] o_rate_x100
);
   function automatic logic [3:0] ptr_inc(input logic [3:0] p);
      ptr_inc = p + 4'h1;
   endfunction : ptr_inc

   function automatic logic [16:0] rate_x100(input rpf_pkg::rpf_mode_e m);
      case (m)
         rpf_pkg::RPF_GFSK: rate_x100 = `RPF_RATE_GFSK;
         rpf_pkg::RPF_OCT32: rate_x100 = `RPF_RATE_OCT32;
         rpf_pkg::RPF_OCT64: rate_x100 = `RPF_RATE_OCT64;
         rpf_pkg::RPF_DBL32: rate_x100 = `RPF_RATE_DBL32;
         rpf_pkg::RPF_DBL64: rate_x100 = `RPF_RATE_DBL64;
         default: rate_x100 = `RPF_RATE_SGL64;
      endcase
   endfunction : rate_x100

   // Marker usage: mandatory GFSK/octal, optional double, none single
   function automatic logic sop_on(input rpf_pkg::rpf_mode_e m, input logic en);
      if (m == rpf_pkg::RPF_SGL64) begin
         sop_on = 1'b0;
      end else if (m == rpf_pkg::RPF_DBL32 || m == rpf_pkg::RPF_DBL64) begin
         sop_on = en;
      end else begin
         sop_on = 1'b1;
      end
   endfunction : sop_on

   function automatic logic len_on(input rpf_pkg::rpf_mode_e m, input logic s, input logic l);
      if (!sop_on(m, s)) begin
         len_on = 1'b0;
      end else if (m == rpf_pkg::RPF_DBL32 || m == rpf_pkg::RPF_DBL64) begin
         len_on = l;
      end else begin
         len_on = 1'b1;
      end
   endfunction : len_on

   // Link sampling: three stages, accept when last two agree
   rpf_pkg::rpf_link_s lk_s1, lk_s2, lk_s3, lk_f;
   logic lk_clk_prev;
   logic lk_edge;

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lk_s1 <= '0;
         lk_s2 <= '0;
         lk_s3 <= '0;
      end else begin
         lk_s1 <= i_link;
         lk_s2 <= lk_s1;
         lk_s3 <= lk_s2;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lk_f <= '0;
         lk_clk_prev <= 1'b0;
      end else begin
         if (lk_s2 == lk_s3) begin
            lk_f <= lk_s3;
         end
         lk_clk_prev <= lk_f.clk;
      end
   end

   assign lk_edge = lk_f.clk & ~lk_clk_prev;

   // Buffers: each strobe touches the FIFO head or tail only
   logic [7:0] tx_mem [0:15];
   logic [7:0] rx_mem [0:15];
   logic [3:0] tx_wp, tx_rp, rx_wp, rx_rp;
   logic tx_push, tx_pop, rx_push, rx_pop;
   logic [7:0] rx_byte;

   rpf_pkg::rpf_txst_e tx_st;
   rpf_pkg::rpf_rxst_e rx_st;
   logic [3:0] tx_bitc, rx_bitc;
   logic [7:0] tx_sh, rx_sh;
   logic [5:0] tx_left, rx_left;
   logic tx_crc_on, tx_bit_now;
   logic [15:0] tx_crc, rx_crc_seed, rx_crc_zero, rx_crc_in;

   assign tx_push = i_txb_wr && (o_tx_level != `RPF_FIFO_DEPTH);
   assign tx_pop = lk_edge && (tx_st == rpf_pkg::TX_PAY) && (tx_bitc == 4'h0)
      && (o_tx_level != 5'h00);
   assign rx_pop = i_rxb_rd && (o_rx_level != 5'h00);
   assign rx_byte = {lk_f.data, rx_sh[7:1]};
   assign rx_push = lk_edge && (rx_st == rpf_pkg::RX_PAY) && (rx_bitc == 4'h7)
      && (o_rx_level != `RPF_FIFO_DEPTH);
   assign tx_bit_now = (tx_bitc == 4'h0) ? tx_mem[tx_rp][0] : tx_sh[0];

   always_ff @(posedge i_clock) begin
      if (tx_push) begin
         tx_mem[tx_wp] <= i_txb_data;
      end
      if (rx_push) begin
         rx_mem[rx_wp] <= rx_byte;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_wp <= 4'h0;
         tx_rp <= 4'h0;
         o_tx_level <= 5'h00;
      end else begin
         if (tx_push) begin
            tx_wp <= ptr_inc(tx_wp);
         end
         if (tx_pop) begin
            tx_rp <= ptr_inc(tx_rp);
         end
         o_tx_level <= o_tx_level + {4'h0, tx_push} - {4'h0, tx_pop};
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rx_wp <= 4'h0;
         rx_rp <= 4'h0;
         o_rx_level <= 5'h00;
         o_rxb_data <= 8'h00;
      end else begin
         if (rx_push) begin
            rx_wp <= ptr_inc(rx_wp);
         end
         if (rx_pop) begin
            rx_rp <= ptr_inc(rx_rp);
            o_rxb_data <= rx_mem[rx_rp];
         end
         o_rx_level <= o_rx_level + {4'h0, rx_push} - {4'h0, rx_pop};
      end
   end

   // Level flags let the host run the buffers as FIFOs for long packets
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_tx_low <= 1'b1;
         o_rx_high <= 1'b0;
         o_rate_x100 <= `RPF_RATE_GFSK;
         o_link_spread <= 1'b0;
      end else begin
         o_tx_low <= (o_tx_level <= `RPF_FIFO_HALF);
         o_rx_high <= (o_rx_level >= `RPF_FIFO_HALF);
         o_rate_x100 <= rate_x100(i_cfg.mode);
         o_link_spread <= (i_cfg.mode != rpf_pkg::RPF_GFSK);
      end
   end

   rpf_crc16 u_tx_crc (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_init(i_tx_start && (tx_st == rpf_pkg::TX_IDLE)),
      .i_seed(i_cfg.crc_zero_seed ? `RPF_CRC_ZERO : i_cfg.crc_seed),
      .i_step(lk_edge && (tx_st == rpf_pkg::TX_PAY) && !(tx_bitc == 4'h0 && o_tx_level == 5'h00)),
      .i_bit(tx_bit_now),
      .o_crc(tx_crc)
   );

   // Transmitter: starts on host strobe, then runs from the buffer alone
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_st <= rpf_pkg::TX_IDLE;
         tx_bitc <= 4'h0;
         tx_sh <= 8'h00;
         tx_left <= 6'h00;
         tx_crc_on <= 1'b0;
         o_link_tx_bit <= 1'b0;
         o_link_tx_en <= 1'b0;
         o_link_sop_tx <= 1'b0;
         o_tx_busy <= 1'b0;
         o_tx_done <= 1'b0;
         o_tx_underrun <= 1'b0;
      end else begin
         o_tx_done <= 1'b0;
         o_tx_underrun <= 1'b0;
         if (tx_st == rpf_pkg::TX_IDLE) begin
            if (i_tx_start && i_tx_len != 6'h00 && i_tx_len <= `RPF_MAX_PKT) begin
               tx_left <= i_tx_len;
               tx_sh <= {2'h0, i_tx_len};
               tx_bitc <= 4'h0;
               tx_crc_on <= i_cfg.crc_en;
               o_tx_busy <= 1'b1;
               tx_st <= sop_on(i_cfg.mode, i_cfg.sop_en) ? rpf_pkg::TX_SOP
                  : rpf_pkg::TX_PAY;
            end
         end else if (lk_edge) begin
            o_link_tx_en <= 1'b1;
            case (tx_st)
               rpf_pkg::TX_SOP: begin
                  o_link_sop_tx <= 1'b1;
                  if (tx_bitc == {2'h0, `RPF_SOP_SYMS} - 4'h1) begin
                     tx_bitc <= 4'h0;
                     tx_st <= len_on(i_cfg.mode, i_cfg.sop_en, i_cfg.len_en)
                        ? rpf_pkg::TX_LEN : rpf_pkg::TX_PAY;
                  end else begin
                     tx_bitc <= tx_bitc + 4'h1;
                  end
               end
               rpf_pkg::TX_LEN: begin
                  o_link_sop_tx <= 1'b0;
                  o_link_tx_bit <= tx_sh[0];
                  tx_sh <= tx_sh >> 1;
                  tx_bitc <= (tx_bitc == `RPF_LEN_BITS - 4'h1) ? 4'h0 : tx_bitc + 4'h1;
                  if (tx_bitc == `RPF_LEN_BITS - 4'h1) begin
                     tx_st <= rpf_pkg::TX_PAY;
                  end
               end
               rpf_pkg::TX_PAY: begin
                  o_link_sop_tx <= 1'b0;
                  if (tx_bitc == 4'h0 && o_tx_level == 5'h00) begin
                     // Radio cannot pause mid-packet: abandon it
                     o_tx_underrun <= 1'b1;
                     o_link_tx_en <= 1'b0;
                     o_tx_busy <= 1'b0;
                     tx_st <= rpf_pkg::TX_IDLE;
                  end else begin
                     o_link_tx_bit <= tx_bit_now;
                     tx_sh <= ((tx_bitc == 4'h0) ? tx_mem[tx_rp] : tx_sh) >> 1;
                     tx_bitc <= (tx_bitc == 4'h7) ? 4'h0 : tx_bitc + 4'h1;
                     if (tx_bitc == 4'h7) begin
                        tx_left <= tx_left - 6'h01;
                        if (tx_left == 6'h01) begin
                           tx_st <= tx_crc_on ? rpf_pkg::TX_CRC : rpf_pkg::TX_FIN;
                        end
                     end
                  end
               end
               rpf_pkg::TX_CRC: begin
                  o_link_tx_bit <= tx_crc[tx_bitc];
                  tx_bitc <= tx_bitc + 4'h1;
                  if (tx_bitc == 4'hf) begin
                     tx_st <= rpf_pkg::TX_FIN;
                  end
               end
               default: begin
                  o_link_tx_en <= 1'b0;
                  o_tx_busy <= 1'b0;
                  o_tx_done <= 1'b1;
                  tx_st <= rpf_pkg::TX_IDLE;
               end
            endcase
         end
      end
   end

   // Receiver
   rpf_pkg::rpf_mode_e rx_mode;
   logic rx_len_on, rx_crc_on, rx_start, rx_corr_prev;
   logic [3:0] rx_nc;
   logic [4:0] rx_crc_bitc;

   // Framed: follow marker at any rate but single; unframed: two correlations
   assign rx_start = lk_edge && (rx_st == rpf_pkg::RX_IDLE) && (i_cfg.framing_en
      ? (lk_f.sop && lk_f.rate != rpf_pkg::RPF_SGL64)
      : (lk_f.corr && rx_corr_prev));

   rpf_crc16 u_rx_crc_seed (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_init(rx_start),
      .i_seed(i_cfg.crc_seed),
      .i_step(lk_edge && (rx_st == rpf_pkg::RX_PAY)),
      .i_bit(lk_f.data),
      .o_crc(rx_crc_seed)
   );

   rpf_crc16 u_rx_crc_zero (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_init(rx_start),
      .i_seed(`RPF_CRC_ZERO),
      .i_step(lk_edge && (rx_st == rpf_pkg::RX_PAY)),
      .i_bit(lk_f.data),
      .o_crc(rx_crc_zero)
   );

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rx_st <= rpf_pkg::RX_IDLE;
         rx_mode <= rpf_pkg::RPF_GFSK;
         rx_len_on <= 1'b0;
         rx_crc_on <= 1'b0;
         rx_corr_prev <= 1'b0;
         rx_bitc <= 4'h0;
         rx_crc_bitc <= 5'h00;
         rx_sh <= 8'h00;
         rx_left <= 6'h00;
         rx_nc <= 4'h0;
         rx_crc_in <= 16'h0000;
         o_rx_busy <= 1'b0;
         o_rx_done <= 1'b0;
         o_rx_crc_ok <= 1'b0;
         o_rx_crc_err <= 1'b0;
         o_rx_overflow <= 1'b0;
         o_rx_len <= 6'h00;
      end else begin
         o_rx_done <= 1'b0;
         o_rx_crc_ok <= 1'b0;
         o_rx_crc_err <= 1'b0;
         o_rx_overflow <= 1'b0;
         if (lk_edge) begin
            rx_corr_prev <= (rx_st == rpf_pkg::RX_IDLE) && lk_f.corr && !rx_start;
         end
         if (rx_start) begin
            rx_mode <= i_cfg.framing_en ? lk_f.rate : i_cfg.mode;
            rx_len_on <= i_cfg.framing_en
               && len_on(lk_f.rate, i_cfg.sop_en, i_cfg.len_en);
            rx_crc_on <= i_cfg.crc_en;
            rx_bitc <= 4'h0;
            rx_nc <= 4'h0;
            o_rx_len <= 6'h00;
            o_rx_busy <= 1'b1;
            rx_st <= (i_cfg.framing_en && len_on(lk_f.rate, i_cfg.sop_en, i_cfg.len_en))
               ? rpf_pkg::RX_LEN : rpf_pkg::RX_PAY;
         end else if (lk_edge && rx_st != rpf_pkg::RX_IDLE) begin
            rx_sh <= rx_byte;
            rx_bitc <= (rx_bitc == 4'h7) ? 4'h0 : rx_bitc + 4'h1;
            case (rx_st)
               rpf_pkg::RX_LEN: begin
                  if (rx_bitc == `RPF_LEN_BITS - 4'h1) begin
                     rx_left <= rx_byte[5:0];
                     rx_crc_bitc <= 5'h00;
                     if (rx_byte == 8'h00) begin
                        rx_st <= rx_crc_on ? rpf_pkg::RX_CRC : rpf_pkg::RX_IDLE;
                        o_rx_done <= !rx_crc_on;
                        o_rx_busy <= rx_crc_on;
                     end else begin
                        rx_st <= rpf_pkg::RX_PAY;
                     end
                  end
               end
               rpf_pkg::RX_PAY: begin
                  rx_nc <= lk_f.corr ? 4'h0 : rx_nc + 4'h1;
                  if (rx_bitc == 4'h7) begin
                     o_rx_overflow <= (o_rx_level == `RPF_FIFO_DEPTH);
                     o_rx_len <= o_rx_len + 6'h01;
                     rx_left <= rx_left - 6'h01;
                  end
                  if (rx_len_on && rx_bitc == 4'h7 && rx_left == 6'h01) begin
                     rx_st <= rx_crc_on ? rpf_pkg::RX_CRC : rpf_pkg::RX_IDLE;
                     o_rx_done <= !rx_crc_on;
                     o_rx_busy <= rx_crc_on;
                     rx_crc_bitc <= 5'h00;
                  end else if (!rx_len_on && !lk_f.corr
                     && rx_mode != rpf_pkg::RPF_GFSK
                     && rx_nc + 4'h1 >= i_cfg.nocorr_limit) begin
                     rx_st <= rpf_pkg::RX_IDLE;
                     o_rx_done <= 1'b1;
                     o_rx_busy <= 1'b0;
                  end
               end
               rpf_pkg::RX_CRC: begin
                  rx_crc_in <= {lk_f.data, rx_crc_in[15:1]};
                  rx_crc_bitc <= rx_crc_bitc + 5'h01;
                  if (rx_crc_bitc == `RPF_CRC_BITS - 5'h01) begin
                     // Either seed is accepted so mixed-seed peers interoperate
                     if ({lk_f.data, rx_crc_in[15:1]} == rx_crc_seed
                        || {lk_f.data, rx_crc_in[15:1]} == rx_crc_zero) begin
                        o_rx_crc_ok <= 1'b1;
                     end else begin
                        o_rx_crc_err <= 1'b1;
                     end
                     o_rx_done <= 1'b1;
                     o_rx_busy <= 1'b0;
                     rx_st <= rpf_pkg::RX_IDLE;
                  end
               end
               default: begin
                  rx_st <= rpf_pkg::RX_IDLE;
               end
            endcase
         end
      end
   end
endmodule : rpf_framer
`default_nettype wire
